/* File: arsc_regs.vh */
// Register map, field positions and reset values of the converter control block
`ifndef ARSC_REGS_VH
`define ARSC_REGS_VH

// Word-aligned byte offsets on the register bus
`define ARSC_OFS_CTRL2 5'h00
`define ARSC_OFS_IRQ_STATUS 5'h04
`define ARSC_OFS_IRQ_MASK 5'h08
`define ARSC_ADDR_W 5

// Second control word fields
`define ARSC_REFS_READY_BIT 31
`define ARSC_REF_FAULT_BIT 30
`define ARSC_SCAN_DONE_BIT 29
`define ARSC_CAP_HI 28
`define ARSC_CAP_LO 26
`define ARSC_SHARED_SAMPLE_TIME_HI 25
`define ARSC_SHARED_SAMPLE_TIME_LO 16
`define ARSC_RDY_IEN_BIT 15
`define ARSC_FLT_IEN_BIT 14
`define ARSC_SCAN_IEN_BIT 13
`define ARSC_EXT_OVR_BIT 12
`define ARSC_EXT_SEL_HI 10
`define ARSC_EXT_SEL_LO 8
`define ARSC_DIV_HI 6
`define ARSC_DIV_LO 0

// Software-writable bits of the second control word, reset value
`define ARSC_CTRL2_WMASK 32'h1FFF_F77F
`define ARSC_CTRL2_RESET 32'h0000_0000

// Interrupt status and mask layout
`define ARSC_IRQ_READY_BIT 0
`define ARSC_IRQ_FAULT_BIT 1
`define ARSC_IRQ_SCAN_BIT 2
`define ARSC_IRQ_W 3
`define ARSC_IRQ_RESET 3'h0

`endif

/* File: arsc_scan_tracker.v */
// Tracks the selected analog inputs of one scan and flags its end
module arsc_scan_tracker #(
   parameter NCH = 64
)(
   // Clock and reset
   input wire clock_i,
   input wire reset_n_i,
   // Scan control
   input wire [NCH-1:0] scan_select_i,
   input wire scan_trigger_i,
   input wire [NCH-1:0] conv_done_i,
   // Result
   output reg scan_end_o
);

   reg [NCH-1:0] pending_q;
   reg [NCH-1:0] pending_d;
   reg active_q;

   // Strike off each converted input; a new trigger restarts the set
   always @*
   begin
      if (scan_trigger_i)
         pending_d = scan_select_i;
      else
         pending_d = pending_q & ~conv_done_i;
   end

   // Scan end pulses once, when the last selected input completes
   always @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         pending_q <= {NCH{1'b0}};
         active_q <= 1'b0;
         scan_end_o <= 1'b0;
      end
      else
      begin
         pending_q <= pending_d;
         scan_end_o <= 1'b0;
         if (scan_trigger_i)
            active_q <= 1'b1;
         else if (active_q && (pending_d == {NCH{1'b0}}))
         begin
            active_q <= 1'b0;
            scan_end_o <= 1'b1;
         end
      end
   end

endmodule

/* File: arsc_sample_timer.v */
// Shared conversion clock divider and sample-time counter
module arsc_sample_timer #(
   parameter DIV_W = 7,
   parameter SHARED_SAMPLE_TIME_W = 10
)(
   // Clock and reset
   input wire clock_i,
   input wire reset_n_i,
   // Settings
   input wire [DIV_W-1:0] divider_i,
   input wire [SHARED_SAMPLE_TIME_W-1:0] sample_time_i,
   // Sampling control
   input wire sample_start_i,
   output reg sampling_o,
   output reg sample_done_o
);

   reg [DIV_W:0] div_cnt_q;
   reg [SHARED_SAMPLE_TIME_W:0] tick_cnt_q;
   wire [DIV_W:0] div_reload;
   wire [SHARED_SAMPLE_TIME_W:0] tick_target;
   wire tick;

   // Period is twice the divider in clocks; zero behaves as one
   assign div_reload = (divider_i == {DIV_W{1'b0}}) ? {{DIV_W{1'b0}}, 1'b1} :
                       ({divider_i, 1'b0} - {{DIV_W{1'b0}}, 1'b1});
   assign tick = (div_cnt_q == {(DIV_W+1){1'b0}});
   // Sample time is the field plus two conversion clock periods
   assign tick_target = {1'b0, sample_time_i} + {{(SHARED_SAMPLE_TIME_W-1){1'b0}}, 2'b10};

   // Divider restarts with each sample so the first period is whole
   always @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         div_cnt_q <= {(DIV_W+1){1'b0}};
         tick_cnt_q <= {(SHARED_SAMPLE_TIME_W+1){1'b0}};
         sampling_o <= 1'b0;
         sample_done_o <= 1'b0;
      end
      else
      begin
         sample_done_o <= 1'b0;
         if (sample_start_i && !sampling_o)
         begin
            sampling_o <= 1'b1;
            div_cnt_q <= div_reload;
            tick_cnt_q <= {(SHARED_SAMPLE_TIME_W+1){1'b0}};
         end
         else if (sampling_o)
         begin
            if (tick)
            begin
               div_cnt_q <= div_reload;
               if (tick_cnt_q + {{SHARED_SAMPLE_TIME_W{1'b0}}, 1'b1} == tick_target)
               begin
                  sampling_o <= 1'b0;
                  sample_done_o <= 1'b1;
               end
               tick_cnt_q <= tick_cnt_q + {{SHARED_SAMPLE_TIME_W{1'b0}}, 1'b1};
            end
            else
               div_cnt_q <= div_cnt_q - {{DIV_W{1'b0}}, 1'b1};
         end
      end
   end

endmodule

/* File: arsc_ctrl.v */
// Converter reference status, scan end and sample timing control with register slave
//
// Functional notes
// - Refs-ready high only while band-gap and reference both ready.
// - Refs-ready forced low whenever the module enable is low.
// - Reference fault flag sets on a reference fault while enabled.
// - Fault flag clears only when disabled and references ready together.
// - Scan-done sets once all selected inputs finish after a trigger.
// - Reading the top byte of the control word clears scan-done.
// - Three-bit divider capacitance code n selects n times 2.5 pF.
// - Sample time equals the ten-bit field plus two conversion clocks.
// - Conversion clock period derives from the seven-bit divider field.
// - Ready interrupt enable gates the interrupt raised when ready sets.

`include "arsc_regs.vh"
module arsc_ctrl #(
   parameter NCH = 64
)(
   // Clock and reset
   input wire clock_i,
   input wire reset_n_i,
   // Avalon-MM slave
   input wire [`ARSC_ADDR_W-1:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   output wire avs_waitrequest_o,
   output reg [31:0] avs_readdata_o,
   // Module enable from the first control word
   input wire module_enable_i,
   // Analog status pins
   input wire bandgap_ready_i,
   input wire vref_ready_i,
   input wire ref_fault_i,
   // Scan control, same clock
   input wire [NCH-1:0] scan_select_i,
   input wire scan_trigger_i,
   input wire [NCH-1:0] conv_done_i,
   // Sampling control, same clock
   input wire sample_start_i,
   output wire sampling_o,
   output wire sample_done_o,
   // Settings and status out
   output wire [2:0] divider_cap_select_o,
   output wire refs_ready_o,
   output wire irq_o
);

   // Three-stage synchronisers for the analog status pins
   reg [2:0] sync1_q;
   reg [2:0] sync2_q;
   reg [2:0] sync3_q;
   reg [2:0] pin_q;

   // Hardware status flags
   reg refs_ready_q;
   reg reference_fault_q;
   reg scan_done_q;

   // Software registers and bus state
   reg [31:0] ctrl2_q;
   reg [`ARSC_IRQ_W-1:0] irq_status_q;
   reg [`ARSC_IRQ_W-1:0] irq_mask_q;
   reg ack_q;
   reg [31:0] rdata_d;
   reg [31:0] wmask;
   wire req;
   wire take;

   // Filtered pin levels and flag terms
   wire bg_ok;
   wire vr_ok;
   wire fault_pin;
   wire refs_ready_d;
   wire fault_set;
   wire fault_clr;
   wire scan_end;
   wire scan_clr;
   wire ready_rise;

   // Interrupt terms
   wire ready_event;
   wire fault_event;
   wire scan_event;
   wire [`ARSC_IRQ_W-1:0] irq_set;
   wire [`ARSC_IRQ_W-1:0] irq_en;

   // Register decode
   wire sel_ctrl2;
   wire sel_status;
   wire sel_mask;
   wire wr_ctrl2;
   wire wr_status;
   wire wr_mask;

   // Pins are asynchronous to the clock; a level counts once it has settled
   // Stage one is read only by stage two
   always @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         sync3_q <= 3'h0;
         pin_q <= 3'h0;
      end
      else
      begin
         sync1_q <= {ref_fault_i, vref_ready_i, bandgap_ready_i};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         // A level change counts only when stages two and three agree
         pin_q <= (sync2_q & sync3_q) | (pin_q & (sync2_q | sync3_q));
      end
   end

   assign bg_ok = pin_q[0];
   assign vr_ok = pin_q[1];
   assign fault_pin = pin_q[2];

   // Fixed single wait keeps the read mux off the bus timing path
   // Bus handshake: one wait cycle, then the request is taken
   assign req = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = req & ~ack_q;
   assign take = req & ack_q;

   // Address decode
   assign sel_ctrl2 = (avs_address_i == `ARSC_OFS_CTRL2);
   assign sel_status = (avs_address_i == `ARSC_OFS_IRQ_STATUS);
   assign sel_mask = (avs_address_i == `ARSC_OFS_IRQ_MASK);
   // Writes land only at the taking edge; status and mask use lane 0
   assign wr_ctrl2 = take & avs_write_i & sel_ctrl2;
   assign wr_status = take & avs_write_i & sel_status & avs_byteenable_i[0];
   assign wr_mask = take & avs_write_i & sel_mask & avs_byteenable_i[0];

   assign refs_ready_d = module_enable_i & bg_ok & vr_ok;

   // A supply dip may show only as a lost reference, not on the fault pin
   // fault pin or lost reference while enabled
   assign fault_set = module_enable_i &
                      (fault_pin | (refs_ready_q & ~(bg_ok & vr_ok)));
   // disabled and references ready; forced flag would never allow it
   assign fault_clr = ~module_enable_i & bg_ok & vr_ok;

   assign scan_clr = take & avs_read_i & sel_ctrl2 & avs_byteenable_i[3];

   assign ready_rise = refs_ready_d & ~refs_ready_q;

   // Interrupt events, one sticky bit each, on the rise of each flag
   assign ready_event = ready_rise;
   assign fault_event = fault_set & ~reference_fault_q;
   assign scan_event = scan_end & ~scan_done_q;
   assign irq_set = {scan_event, fault_event, ready_event};

   // ready interrupt enable gates its request
   // fault and scan enables gate theirs
   assign irq_en = {ctrl2_q[`ARSC_SCAN_IEN_BIT], ctrl2_q[`ARSC_FLT_IEN_BIT],
                    ctrl2_q[`ARSC_RDY_IEN_BIT]};
   // Level output; drops once software clears the status bit
   assign irq_o = |(irq_status_q & irq_mask_q & irq_en);

   // Status flags held by hardware; a set in the clear cycle wins
   always @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         refs_ready_q <= 1'b0;
         reference_fault_q <= 1'b0;
         scan_done_q <= 1'b0;
      end
      else
      begin
         refs_ready_q <= refs_ready_d;
         if (fault_set)
            reference_fault_q <= 1'b1;
         else if (fault_clr)
            reference_fault_q <= 1'b0;
         if (scan_end)
            scan_done_q <= 1'b1;
         else if (scan_clr)
            scan_done_q <= 1'b0;
      end
   end

   // Byte-lane write mask limited to writable fields
   always @*
   begin
      wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
               {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
      // unimplemented and status bits ignore writes
      wmask = wmask & `ARSC_CTRL2_WMASK;
   end

   // Software registers; writes land at the edge with waitrequest low
   always @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         ctrl2_q <= `ARSC_CTRL2_RESET;
         irq_status_q <= `ARSC_IRQ_RESET;
         irq_mask_q <= `ARSC_IRQ_RESET;
      end
      else
      begin
         if (wr_ctrl2)
            ctrl2_q <= (ctrl2_q & ~wmask) | (avs_writedata_i & wmask);
         if (wr_mask)
            irq_mask_q <= avs_writedata_i[`ARSC_IRQ_W-1:0];
         // Write one to clear, but a new event in the same cycle survives
         if (wr_status)
            irq_status_q <= (irq_status_q & ~avs_writedata_i[`ARSC_IRQ_W-1:0]) | irq_set;
         else
            irq_status_q <= irq_status_q | irq_set;
      end
   end

   // Read mux; unmapped addresses read zero
   always @*
   begin
      rdata_d = 32'h0000_0000;
      if (sel_ctrl2)
      begin
         // bits 11 and 7 keep the zero default
         rdata_d[`ARSC_CAP_HI:`ARSC_CAP_LO] = ctrl2_q[`ARSC_CAP_HI:`ARSC_CAP_LO];
         rdata_d[`ARSC_SHARED_SAMPLE_TIME_HI:`ARSC_SHARED_SAMPLE_TIME_LO] = ctrl2_q[`ARSC_SHARED_SAMPLE_TIME_HI:`ARSC_SHARED_SAMPLE_TIME_LO];
         rdata_d[`ARSC_RDY_IEN_BIT] = ctrl2_q[`ARSC_RDY_IEN_BIT];
         rdata_d[`ARSC_FLT_IEN_BIT] = ctrl2_q[`ARSC_FLT_IEN_BIT];
         rdata_d[`ARSC_SCAN_IEN_BIT] = ctrl2_q[`ARSC_SCAN_IEN_BIT];
         rdata_d[`ARSC_EXT_OVR_BIT] = ctrl2_q[`ARSC_EXT_OVR_BIT];
         rdata_d[`ARSC_EXT_SEL_HI:`ARSC_EXT_SEL_LO] = ctrl2_q[`ARSC_EXT_SEL_HI:`ARSC_EXT_SEL_LO];
         rdata_d[`ARSC_DIV_HI:`ARSC_DIV_LO] = ctrl2_q[`ARSC_DIV_HI:`ARSC_DIV_LO];
         // Hardware flags come from their own registers
         rdata_d[`ARSC_REFS_READY_BIT] = refs_ready_q;
         rdata_d[`ARSC_REF_FAULT_BIT] = reference_fault_q;
         rdata_d[`ARSC_SCAN_DONE_BIT] = scan_done_q;
      end
      else if (sel_status)
         rdata_d[`ARSC_IRQ_W-1:0] = irq_status_q;
      else if (sel_mask)
         rdata_d[`ARSC_IRQ_W-1:0] = irq_mask_q;
   end

   // Loading only in the wait cycle keeps read data still while taken
   // Read data captured in the wait cycle, stands at the taking edge
   always @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         ack_q <= 1'b0;
         avs_readdata_o <= 32'h0000_0000;
      end
      else
      begin
         ack_q <= req & ~ack_q;
         if (avs_read_i && !ack_q)
            avs_readdata_o <= rdata_d;
      end
   end

   // Conversions finished before the trigger do not count toward a scan
   // end-of-scan detection over selected inputs
   arsc_scan_tracker #(
      .NCH(NCH)
   ) u_scan (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .scan_select_i(scan_select_i),
      .scan_trigger_i(scan_trigger_i),
      .conv_done_i(conv_done_i),
      .scan_end_o(scan_end)
   );

   // sample time from field plus two
   // conversion clock from divider field
   // Field widths fixed by the register layout
   arsc_sample_timer #(
      .DIV_W(7),
      .SHARED_SAMPLE_TIME_W(10)
   ) u_sample (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .divider_i(ctrl2_q[`ARSC_DIV_HI:`ARSC_DIV_LO]),
      .sample_time_i(ctrl2_q[`ARSC_SHARED_SAMPLE_TIME_HI:`ARSC_SHARED_SAMPLE_TIME_LO]),
      .sample_start_i(sample_start_i),
      .sampling_o(sampling_o),
      .sample_done_o(sample_done_o)
   );

   // capacitance code passed to the divider array, 2.5 pF steps
   assign divider_cap_select_o = ctrl2_q[`ARSC_CAP_HI:`ARSC_CAP_LO];
   // Refs-ready leaves as the registered flag, free of glitches
   assign refs_ready_o = refs_ready_q;

endmodule

/* File: arsc_ctrl_assertions.sv */
// Port-level checks of the converter control block
`include "arsc_regs.vh"
module arsc_ctrl_assertions #(
   parameter NCH = 64
)(
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // Register bus
   input wire logic [`ARSC_ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic avs_waitrequest_o,
   input wire logic [31:0] avs_readdata_o,
   // Analog status and scan
   input wire logic module_enable_i,
   input wire logic bandgap_ready_i,
   input wire logic vref_ready_i,
   input wire logic ref_fault_i,
   input wire logic [NCH-1:0] scan_select_i,
   input wire logic scan_trigger_i,
   input wire logic [NCH-1:0] conv_done_i,
   // Sampling and outputs
   input wire logic sample_start_i,
   input wire logic sampling_o,
   input wire logic sample_done_o,
   input wire logic [2:0] divider_cap_select_o,
   input wire logic refs_ready_o,
   input wire logic irq_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);
   // Read taken at this edge
   wire logic rd_take = avs_read_i & ~avs_waitrequest_o;

   // Bus answer timing and read contents
   bus_wait_first_a: assert property ($rose(avs_read_i | avs_write_i) |-> avs_waitrequest_o)
      else $error("no wait cycle");
   bus_one_wait_a: assert property ((avs_read_i | avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o) else $error("more than one wait cycle");
   unmapped_zero_a: assert property (rd_take && avs_address_i > 5'h08 |-> avs_readdata_o == 32'h0)
      else $error("unmapped read not zero");
   unimpl_zero_a: assert property (rd_take && avs_address_i == `ARSC_OFS_CTRL2 |->
      avs_readdata_o[11] == 1'b0 && avs_readdata_o[7] == 1'b0) else $error("bit 11 or 7 set");
   // Flag and setting relations
   rdy_forced_low_a: assert property (!module_enable_i |=> !refs_ready_o)
      else $error("ready while disabled");
   rdy_needs_refs_a: assert property ((!bandgap_ready_i || !vref_ready_i) [*8]
      |-> !refs_ready_o) else $error("ready without references");
   cap_write_a: assert property (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[3]
      && avs_address_i == `ARSC_OFS_CTRL2 |=> divider_cap_select_o == $past(avs_writedata_i[28:26]))
      else $error("cap select not updated");
   done_pulse_a: assert property (sample_done_o |-> !sampling_o && $past(sampling_o))
      else $error("done pulse not at end of sampling");
   start_sample_a: assert property (sample_start_i && !sampling_o && !sample_done_o
      |=> sampling_o) else $error("start ignored");
   done_single_a: assert property (sample_done_o |=> !sample_done_o)
      else $error("done pulse too long");
   // Main scenarios reached
   cover property (sample_done_o);
   cover property ($rose(refs_ready_o));
   cover property ($rose(irq_o));
endmodule

bind arsc_ctrl arsc_ctrl_assertions #(.NCH(NCH)) chk_u (.*);

/* File: arsc_ctrl_test.sv */
// Self-checking bench of the converter control block
`include "arsc_regs.vh"
module arsc_ctrl_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam NCH = 4;
   logic clock_i, reset_n_i, avs_read_i, avs_write_i, avs_waitrequest_o;
   logic [4:0] avs_address_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, rd;
   logic [3:0] avs_byteenable_i, scan_select_i, conv_done_i;
   logic module_enable_i, bandgap_ready_i, vref_ready_i, ref_fault_i, scan_trigger_i;
   logic sample_start_i, sampling_o, sample_done_o, refs_ready_o, irq_o;
   logic [2:0] divider_cap_select_o;
   logic [6:0] dv [4] = '{7'h00, 7'h03, 7'h01, 7'h00};
   logic [9:0] sm [4] = '{10'h000, 10'h001, 10'h000, 10'h3FF};
   int failures, comparisons, n, k;

   arsc_ctrl #(.NCH(NCH)) dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_waitrequest_o(avs_waitrequest_o), .avs_readdata_o(avs_readdata_o),
      .module_enable_i(module_enable_i), .bandgap_ready_i(bandgap_ready_i),
      .vref_ready_i(vref_ready_i), .ref_fault_i(ref_fault_i), .scan_select_i(scan_select_i),
      .scan_trigger_i(scan_trigger_i), .conv_done_i(conv_done_i),
      .sample_start_i(sample_start_i), .sampling_o(sampling_o), .sample_done_o(sample_done_o),
      .divider_cap_select_o(divider_cap_select_o), .refs_ready_o(refs_ready_o), .irq_o(irq_o));

   // Free-running 10 MHz clock
   initial
   begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end

   task tick(input int c);
      repeat (c) @(posedge clock_i);
   endtask

   task check(input logic [31:0] got, input logic [31:0] exp, input string m);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   // One bus cycle; request held until waitrequest is sampled low
   task bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge clock_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_byteenable_i <= be;
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      k = 0;
      do
      begin
         @(posedge clock_i);
         k++;
      end
      while (avs_waitrequest_o !== 1'b0);
      // Exactly one wait cycle, then the taking edge
      check(k, 2, "bus answer");
      rd = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask

   // Analog pins, then time for the synchronisers to settle
   task pins(input logic en, input logic bg, input logic vr, input logic ft);
      module_enable_i <= en;
      bandgap_ready_i <= bg;
      vref_ready_i <= vr;
      ref_fault_i <= ft;
      tick(8);
   endtask

   task print_verdict;
      $display("counts: %0d comparisons, %0d failures", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Watchdog well beyond the expected run of about 2300 cycles
   initial
   begin
      #1ms;
      failures++;
      print_verdict;
   end

   // Main sequence
   initial
   begin
      {avs_address_i, avs_read_i, avs_write_i, avs_writedata_i, avs_byteenable_i} = '0;
      {module_enable_i, bandgap_ready_i, vref_ready_i, ref_fault_i, scan_trigger_i} = '0;
      {scan_select_i, conv_done_i, sample_start_i} = '0;
      reset_n_i = 1'b0;
      tick(4);
      reset_n_i <= 1'b1;
      bus(0, `ARSC_OFS_CTRL2, 0, 4'hF);
      check(rd, 32'h0, "ctrl2 reset");
      bus(0, 5'h1C, 0, 4'hF);
      check(rd, 32'h0, "unmapped read");
      bus(1, `ARSC_OFS_CTRL2, 32'hFFFF_FFFF, 4'hF);
      bus(0, `ARSC_OFS_CTRL2, 0, 4'hF);
      check(rd, 32'h1FFF_F77F, "writable bits");
      for (int i = 0; i < 8; i++)
      begin
         bus(1, `ARSC_OFS_CTRL2, i << 26, 4'hF);
         tick(1);
         check(divider_cap_select_o, i, "cap code");
      end
      // Sample length is (field + 2) periods of twice the divider, zero acting as one
      for (int i = 0; i < 4; i++)
      begin
         bus(1, `ARSC_OFS_CTRL2, {6'h00, sm[i], 9'h000, dv[i]}, 4'hF);
         sample_start_i <= 1'b1;
         tick(1);
         sample_start_i <= 1'b0;
         n = 0;
         for (k = 0; k < 3000 && sample_done_o !== 1'b1; k++)
         begin
            @(posedge clock_i);
            if (sampling_o === 1'b1) n++;
         end
         check(n, (sm[i] + 2) * (dv[i] == 0 ? 2 : 2 * dv[i]), "sample length");
      end
      $display("test registers and sampling done");
      bus(1, `ARSC_OFS_IRQ_MASK, 32'h7, 4'h1);
      bus(1, `ARSC_OFS_CTRL2, 0, 4'hF);
      pins(1, 1, 1, 0);
      check(refs_ready_o, 1'b1, "ready");
      check(irq_o, 1'b0, "irq gated off");
      bus(0, `ARSC_OFS_IRQ_STATUS, 0, 4'h1);
      check(rd, 32'h1, "ready event");
      bus(1, `ARSC_OFS_CTRL2, 32'h0000_E000, 4'hF);
      tick(1);
      check(irq_o, 1'b1, "irq");
      bus(1, `ARSC_OFS_IRQ_STATUS, 32'h7, 4'h1);
      tick(1);
      check(irq_o, 1'b0, "irq clear");
      pins(1, 1, 0, 0);
      bus(0, `ARSC_OFS_CTRL2, 0, 4'hF);
      check(rd, 32'h4000_E000, "drop");
      check(irq_o, 1'b1, "fault irq");
      pins(0, 1, 0, 0);
      bus(0, `ARSC_OFS_CTRL2, 0, 4'hF);
      check(rd, 32'h4000_E000, "kept");
      pins(0, 1, 1, 0);
      bus(0, `ARSC_OFS_CTRL2, 0, 4'hF);
      check(rd, 32'h0000_E000, "clr");
      pins(1, 1, 1, 1);
      bus(0, `ARSC_OFS_CTRL2, 0, 4'hF);
      check(rd, 32'hC000_E000, "pin");
      pins(0, 1, 1, 0);
      bus(0, `ARSC_OFS_CTRL2, 0, 4'hF);
      check(rd, 32'h0000_E000, "clr");
      $display("test references done");
      pins(1, 1, 1, 0);
      bus(1, `ARSC_OFS_IRQ_STATUS, 32'h7, 4'h1);
      scan_select_i <= 4'h5;
      scan_trigger_i <= 1'b1;
      tick(1);
      scan_trigger_i <= 1'b0;
      conv_done_i <= 4'h1;
      tick(1);
      conv_done_i <= 4'h0;
      tick(3);
      bus(0, `ARSC_OFS_CTRL2, 0, 4'h7);
      check(rd[29], 1'b0, "scan early");
      conv_done_i <= 4'h4;
      tick(1);
      conv_done_i <= 4'h0;
      tick(3);
      bus(0, `ARSC_OFS_CTRL2, 0, 4'h7);
      check(rd[29], 1'b1, "scan end");
      bus(0, `ARSC_OFS_IRQ_STATUS, 0, 4'h1);
      check(rd, 32'h4, "scan event");
      check(irq_o, 1'b1, "scan irq");
      bus(0, `ARSC_OFS_CTRL2, 0, 4'hF);
      check(rd[29], 1'b1, "top read");
      bus(0, `ARSC_OFS_CTRL2, 0, 4'hF);
      check(rd[29], 1'b0, "cleared");
      $display("test scan done");
      print_verdict;
   end
endmodule
